// [rtl/instruction_clock_watchdog.sv]
// instruction clock watchdog core with reset pin pull-down
//
// Function
// - load all ones, count down per instruction
// - count at zero underflows, sets first flag
// - underflow with first flag sets second, resets
// - watchdog reset turns on reset pin pull-down
// - watchdog reset acts while enable flag set
// - only disable then refresh clears enable
// - enable flag set at reset, back-up entry
// - refresh clears set first flag, skips next
// - skip works with watchdog disabled
// - back-up entry reinitialises first flag, counter
// - watchdog active again after back-up return
`timescale 1ns/1ps
`default_nettype none
`include "wdg_cfg.svh"
module instruction_clock_watchdog
  import wdg_pkg::*;
#(
  parameter int CNT_W = `WDG_CNT_W // counter width
) (
  input  wire logic CLK,            // system clock, 200 mhz
  input  wire logic RST_N,          // asynchronous reset, active low
  input  wire logic INST_TICK,      // instruction clock count pulse
  input  wire logic REFRESH_OP,     // refresh instruction strobe
  input  wire logic DISABLE_OP,     // disable instruction strobe
  input  wire logic OTHER_OP,       // other instruction completes
  input  wire logic BACKUP_ENTRY,   // ram back-up entry pulse
  output logic      SKIP_NEXT,      // skip next instruction pulse
  output logic      RESET_PIN_O,    // reset pin drive value, low
  output logic      RESET_PIN_OE_N, // reset pin pull-down on, active low
  output logic      ENABLE_FLAG,    // guard enable flag
  output logic      EXPIRY1,        // first expiry flag
  output logic      EXPIRY2         // second expiry flag
);
  logic             rst_meta;            // reset sync stage one
  logic             rst_n;               // synchronised reset
  logic [CNT_W-1:0] watchdog_counter;    // down counter
  logic [CNT_W-1:0] next_watchdog_counter;
  logic             guard_enable_flag;   // watchdog on
  logic             next_guard_enable_flag;
  logic             first_expiry_flag;   // first underflow seen
  logic             next_first_expiry_flag;
  logic             second_expiry_flag;  // watchdog reset asserted
  logic             next_second_expiry_flag;
  logic             skip;                // skip pulse register
  logic             next_skip;
  logic             underflow;           // count pulse at zero
  wdg_op_if         ops ();              // decoded strobes

  // reload and zero values cut to the counter width; the 16-bit
  // constants stay as they are so a short counter reuses them
  localparam logic [CNT_W-1:0] CNT_ALL_ONES = CNT_W'(`WDG_CNT_RESET); // reload value
  localparam logic [CNT_W-1:0] CNT_ZERO     = CNT_W'(`WDG_CNT_ZERO);  // underflow point

  // =========================================
  // reset release synchroniser; reset takes hold at once, but its release
  // is retimed so that no flop sees it close to a clock edge
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // =========================================
  // instruction pair decoder; the pair state lives apart so the core
  // sees one clean strobe for a completed disable-then-refresh pair
  wdg_pair_detect u_pair (
    .clk        (CLK),
    .rst_n      (rst_n),
    .backup     (BACKUP_ENTRY),
    .disable_op (DISABLE_OP),
    .refresh_op (REFRESH_OP),
    .other_op   (OTHER_OP),
    .ops        (ops)
  );

  // =========================================
  // counter and flags
  // underflow is the count pulse that finds the counter at zero; the
  // decrement then wraps to all ones, which is the reload itself
  assign underflow = INST_TICK && (watchdog_counter == CNT_ZERO);

  // later branches take priority, so back-up entry overrides all above except the skip pulse

  always_comb begin
    next_watchdog_counter   = watchdog_counter;
    next_guard_enable_flag  = guard_enable_flag;
    next_first_expiry_flag  = first_expiry_flag;
    next_second_expiry_flag = second_expiry_flag;
    next_skip               = 1'b0;
    if (INST_TICK) begin
      next_watchdog_counter = watchdog_counter - 1'b1; // wraps to all ones
    end
    // refresh skip works regardless of enable
    if (ops.refresh && first_expiry_flag) begin
      next_skip              = 1'b1;
      next_first_expiry_flag = 1'b0;
    end
    if (underflow) begin
      next_first_expiry_flag = 1'b1;  // set wins over clear
      if (first_expiry_flag && guard_enable_flag &&
          !(ops.refresh)) begin
        next_second_expiry_flag = 1'b1;
      end
    end
    if (ops.pair_done) begin
      next_guard_enable_flag = 1'b0;
    end
    if (BACKUP_ENTRY) begin
      next_guard_enable_flag  = `WDG_EN_RESET;
      next_first_expiry_flag  = `WDG_FLAG_RESET;
      next_watchdog_counter   = CNT_ALL_ONES;
      // a second expiry neither starts nor ends on back-up entry
      next_second_expiry_flag = second_expiry_flag;
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_counter   <= CNT_ALL_ONES;
      guard_enable_flag  <= `WDG_EN_RESET;
      first_expiry_flag  <= `WDG_FLAG_RESET;
      second_expiry_flag <= `WDG_FLAG_RESET;
      skip               <= 1'b0;
    end else begin
      watchdog_counter   <= next_watchdog_counter;
      guard_enable_flag  <= next_guard_enable_flag;
      first_expiry_flag  <= next_first_expiry_flag;
      second_expiry_flag <= next_second_expiry_flag;
      skip               <= next_skip;
    end
  end

  // =========================================
  // outputs; the pull-down holds until system reset
  assign RESET_PIN_O    = 1'b0;
  assign RESET_PIN_OE_N = !second_expiry_flag;
  assign SKIP_NEXT      = skip;
  assign ENABLE_FLAG    = guard_enable_flag;
  assign EXPIRY1        = first_expiry_flag;
  assign EXPIRY2        = second_expiry_flag;

  // =========================================
  // checks
  sequence s_second_underflow;
    underflow && first_expiry_flag && guard_enable_flag && !ops.refresh && !BACKUP_ENTRY;
  endsequence

  a_count_down_step: assert property (@(posedge CLK) disable iff (!rst_n)
    INST_TICK && !BACKUP_ENTRY |=> watchdog_counter == $past(watchdog_counter) - 1'b1)
    else $error("counter did not step down");
  a_underflow_sets_first: assert property (@(posedge CLK) disable iff (!rst_n)
    underflow && !BACKUP_ENTRY |=> first_expiry_flag && watchdog_counter == CNT_ALL_ONES)
    else $error("underflow did not set first flag");
  a_second_expiry_set: assert property (@(posedge CLK) disable iff (!rst_n)
    s_second_underflow |=> second_expiry_flag)
    else $error("second flag not set");
  a_pin_pull_down: assert property (@(posedge CLK) disable iff (!rst_n)
    second_expiry_flag |-> !RESET_PIN_OE_N && !RESET_PIN_O)
    else $error("reset pin not pulled low");
  a_disabled_no_reset: assert property (@(posedge CLK) disable iff (!rst_n)
    !guard_enable_flag && !second_expiry_flag |=> !second_expiry_flag)
    else $error("reset while disabled");
  a_enable_clear_pair: assert property (@(posedge CLK) disable iff (!rst_n)
    $fell(guard_enable_flag) |-> $past(ops.pair_done))
    else $error("enable cleared without pair");
  a_backup_reinit: assert property (@(posedge CLK) disable iff (!rst_n)
    BACKUP_ENTRY |=> guard_enable_flag && !first_expiry_flag
                     && watchdog_counter == CNT_ALL_ONES)
    else $error("back-up entry did not reinitialise");
  a_refresh_skip: assert property (@(posedge CLK) disable iff (!rst_n)
    REFRESH_OP |=> SKIP_NEXT == $past(first_expiry_flag))
    else $error("skip wrong for refresh");
  a_skip_clears_first: assert property (@(posedge CLK) disable iff (!rst_n)
    REFRESH_OP && first_expiry_flag && !underflow |=> !first_expiry_flag)
    else $error("refresh did not clear first flag");

  // counter: moves only on a count pulse or a back-up entry
  a_counter_holds: assert property (@(posedge CLK) disable iff (!rst_n)
    !INST_TICK && !BACKUP_ENTRY |=> $stable(watchdog_counter))
    else $error("counter moved without a count pulse");

  // flags: each has one cause, the second one is sticky
  a_first_needs_event: assert property (@(posedge CLK) disable iff (!rst_n)
    $rose(first_expiry_flag) |-> $past(underflow))
    else $error("first flag set without underflow");
  a_reset_needs_first: assert property (@(posedge CLK) disable iff (!rst_n)
    $rose(second_expiry_flag) |-> $past(first_expiry_flag) && $past(guard_enable_flag))
    else $error("second flag set without first flag");
  a_second_sticky: assert property (@(posedge CLK) disable iff (!rst_n)
    second_expiry_flag |=> second_expiry_flag)
    else $error("second flag dropped before reset");
  a_skip_needs_refresh: assert property (@(posedge CLK) disable iff (!rst_n)
    !REFRESH_OP |=> !SKIP_NEXT)
    else $error("skip without refresh");

  // pin: the pull-down holds until system reset
  a_pin_stays_low: assert property (@(posedge CLK) disable iff (!rst_n)
    !RESET_PIN_OE_N |=> !RESET_PIN_OE_N)
    else $error("reset pin released before reset");

  // pair handling: a disable directly followed by a refresh
  sequence s_pair_issue;
    (DISABLE_OP && !BACKUP_ENTRY) ##1 (REFRESH_OP && !BACKUP_ENTRY);
  endsequence

  sequence s_disable_no_refresh;
    DISABLE_OP ##1 !REFRESH_OP;
  endsequence

  a_pair_clears_enable: assert property (@(posedge CLK) disable iff (!rst_n)
    s_pair_issue |=> !guard_enable_flag)
    else $error("pair did not clear enable");
  a_disable_alone: assert property (@(posedge CLK) disable iff (!rst_n)
    s_disable_no_refresh |=> !$fell(guard_enable_flag))
    else $error("disable alone stopped the watchdog");
  a_other_breaks_pair: assert property (@(posedge CLK) disable iff (!rst_n)
    OTHER_OP && !DISABLE_OP |=> !ops.pair_done)
    else $error("pair survived another instruction");
endmodule // instruction_clock_watchdog
`default_nettype wire

// [rtl/wdg_cfg.svh]
// constants of the instruction clock watchdog
`ifndef WDG_CFG_SVH
`define WDG_CFG_SVH
`define WDG_CNT_W      16
`define WDG_CNT_RESET  16'hffff
`define WDG_CNT_ZERO   16'h0000
`define WDG_FLAG_RESET 1'b0
`define WDG_EN_RESET   1'b1
`endif

// [rtl/wdg_op_if.sv]
// decoded instruction strobes between decoder and watchdog core
`timescale 1ns/1ps
`default_nettype none
interface wdg_op_if;
  logic refresh;   // refresh instruction completes
  logic pair_done; // disable directly followed by refresh
  modport dec  (output refresh, output pair_done);
  modport core (input refresh, input pair_done);
endinterface
`default_nettype wire

// [rtl/wdg_pair_detect.sv]
// detects the disable-then-refresh instruction pair
`timescale 1ns/1ps
`default_nettype none
module wdg_pair_detect
  import wdg_pkg::*;
(
  input  wire logic clk,       // system clock
  input  wire logic rst_n,     // synchronised reset, active low
  input  wire logic backup,    // ram back-up entry pulse
  input  wire logic disable_op,// disable instruction strobe
  input  wire logic refresh_op,// refresh instruction strobe
  input  wire logic other_op,  // any other instruction completes
  wdg_op_if.dec     ops        // decoded strobes out
);
  pair_state_t state;      // pair tracking state
  pair_state_t next_state; // next pair state

  // =========================================
  // pair tracking
  always_comb begin
    next_state = state;
    case (state)
      PAIR_IDLE: begin
        if (disable_op) next_state = PAIR_ARMED;
      end
      PAIR_ARMED: begin
        if (refresh_op || other_op || backup) next_state = PAIR_IDLE;
        if (disable_op) next_state = PAIR_ARMED;
      end
      default: next_state = PAIR_IDLE;
    endcase
    if (backup) next_state = PAIR_IDLE; // back-up breaks a pending pair
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state <= PAIR_IDLE;
    else        state <= next_state;
  end

  assign ops.refresh   = refresh_op;
  assign ops.pair_done = (state == PAIR_ARMED) && refresh_op && !backup;

  a_pair_needs_disable: assert property (@(posedge clk) disable iff (!rst_n)
    ops.pair_done |-> $past(disable_op) || $past(state == PAIR_ARMED))
    else $error("pair without disable");
endmodule // wdg_pair_detect
`default_nettype wire

// [rtl/wdg_pkg.sv]
// types shared by the watchdog modules
package wdg_pkg;
  typedef enum logic [1:0] {
    PAIR_IDLE,
    PAIR_ARMED
  } pair_state_t;
endpackage

// [verification/instruction_clock_watchdog_test.sv]
// self-checking bench of the instruction clock watchdog
`timescale 1ns/1ps
`default_nettype none
module instruction_clock_watchdog_test;
  localparam int W = 4;                   // short counter for quick expiry
  localparam int TOP = (1 << W) - 1;      // all ones of the short counter
  logic        clk = 1'b0;                // system clock
  logic        rst_n = 1'b0;              // reset, active low
  logic        quiet = 1'b1;              // core idle
  logic        careful = 1'b0;            // core keeps the refresh interval
  logic [15:0] rnd = 16'hf76e;            // random word, starts at 63342
  logic        tick, refr, dis, oth, bkp; // core strobes
  logic        skip, pin_o, pin_oe_n, en_f, ex1, ex2; // watchdog outputs
  int          cnt, fails = 0, checks = 0; // model counter, tallies
  bit          m_e1, m_e2, m_en, armed, m_skip, uf; // model state
  always #2.5 clk = ~clk;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  always @(posedge clk) rnd <= lfsr(rnd);
  wdg_core_model core (.clk(clk), .rnd(rnd), .careful(careful), .quiet(quiet), .tick(tick),
    .guard_refresh_op(refr), .guard_disable_op(dis), .other(oth), .backup(bkp));
  instruction_clock_watchdog #(.CNT_W(W)) dut (.CLK(clk), .RST_N(rst_n), .INST_TICK(tick),
    .REFRESH_OP(refr), .DISABLE_OP(dis), .OTHER_OP(oth), .BACKUP_ENTRY(bkp), .SKIP_NEXT(skip),
    .RESET_PIN_O(pin_o), .RESET_PIN_OE_N(pin_oe_n), .ENABLE_FLAG(en_f), .EXPIRY1(ex1),
    .EXPIRY2(ex2));
  // ==========================================
  // reference model, one step per rising edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {cnt, m_e1, m_e2, m_en, armed, m_skip} = {TOP, 5'h04};
    end else begin
      m_skip = refr && m_e1;
      if (bkp) begin
        {cnt, m_e1, m_en, armed} = {TOP, 3'h2};
      end else begin
        uf = tick && (cnt == 0);
        if (tick) cnt = (cnt - 1) & TOP;
        if (uf && m_e1 && m_en && !refr) m_e2 = 1'b1;
        if (uf) m_e1 = 1'b1;
        else if (refr) m_e1 = 1'b0;
        if (refr && armed) m_en = 1'b0;
        armed = dis ? 1'b1 : ((oth || refr) ? 1'b0 : armed);
      end
    end
  end
  task automatic chk(input string n, input logic e, input logic s);
    checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", n, e, s);
    end
  endtask
  // ==========================================
  // compare every cycle once outputs settle
  always @(posedge clk) begin
    #2;
    chk("SKIP_NEXT", m_skip, skip);
    chk("EXPIRY1", m_e1, ex1);
    chk("EXPIRY2", m_e2, ex2);
    chk("RESET_PIN_OE_N", !m_e2, pin_oe_n);
    chk("RESET_PIN_O", 1'b0, pin_o);
    chk("ENABLE_FLAG", m_en, en_f);
  end
  task automatic results;
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic do_reset;
    quiet <= 1'b1;
    rst_n <= 1'b0;
    repeat (3) @(negedge clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk);
    quiet <= 1'b0;
  endtask
  // ==========================================
  // careful and careless phases, reset after a second expiry
  initial begin
    do_reset();
    for (int ph = 0; ph < 6; ph++) begin
      careful <= (ph % 2 == 1);
      repeat (1200) begin
        @(negedge clk);
        if (m_e2) do_reset();
      end
    end
    results();
  end
  initial begin
    #100000;
    fails++;
    results();
  end
endmodule // instruction_clock_watchdog_test
`default_nettype wire

// [verification/wdg_core_model.sv]
// core model issuing the watchdog instruction strobes
`timescale 1ns/1ps
`default_nettype none
module wdg_core_model #(
  parameter int LIMIT = 12 // longest refresh gap when careful
) (
  input  wire logic        clk,              // system clock
  input  wire logic [15:0] rnd,              // random choice word
  input  wire logic        careful,          // keep the refresh interval
  input  wire logic        quiet,            // issue nothing
  output logic             tick,             // instruction clock pulse
  output logic             guard_refresh_op, // refresh strobe
  output logic             guard_disable_op, // disable strobe
  output logic             other,            // other instruction
  output logic             backup            // back-up entry
);
  int   gap     = 0;    // cycles since the last refresh
  logic bk_pend = 1'b0; // back-up follows the refresh just issued
  logic rare;           // careless core seldom refreshes or disables
  initial {tick, guard_refresh_op, guard_disable_op, other, backup} = 5'h00;
  // ==========================================
  // strobe choice, changed on the falling edge
  always @(negedge clk) begin
    rare = careful || (rnd[7:5] == 3'h0);
    {tick, guard_refresh_op, guard_disable_op, other, backup} <= 5'h00;
    gap <= gap + 1;
    if (quiet) begin
      bk_pend <= 1'b0;
    end else if (bk_pend) begin
      backup  <= 1'b1;
      bk_pend <= 1'b0;
    end else if ((careful && gap >= LIMIT) || (rnd[2:0] == 3'h0 && rare)) begin
      guard_refresh_op <= 1'b1;
      gap              <= 0;
    end else if (rnd[2:0] == 3'h3 && rnd[15:11] == 5'h00) begin
      guard_refresh_op <= 1'b1;
      bk_pend          <= 1'b1;
      gap              <= 0;
    end else begin
      guard_disable_op <= (rnd[2:0] == 3'h1) && rare;
      other            <= (rnd[2:0] == 3'h2);
    end
    if (!quiet && !bk_pend) tick <= rnd[3] | rnd[4];
  end
endmodule // wdg_core_model
`default_nettype wire
